//--- ief_pkg.sv
// package for the interrupt enable and factor flag bank
// assumes a 32-bit apb slave on a 20-bit byte address, one word per register
package ief_pkg;

    // bus shape
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_ENABLE     = 16'hff26;
    localparam logic [15:0] IDX_KEY_FLAGS  = 16'hff27;
    localparam logic [15:0] IDX_TMR_FLAGS  = 16'hff28;
    localparam logic [15:0] IDX_CLK_FLAGS  = 16'hff29;
    localparam logic [15:0] IDX_KEY_MASK   = 16'hff30;
    localparam logic [15:0] IDX_TMR_MASK   = 16'hff31;
    localparam logic [15:0] IDX_CLK_MASK   = 16'hff32;

    localparam logic [ADDR_W-1:0] ADDR_ENABLE    = {2'b00, IDX_ENABLE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_KEY_FLAGS = {2'b00, IDX_KEY_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TMR_FLAGS = {2'b00, IDX_TMR_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CLK_FLAGS = {2'b00, IDX_CLK_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_KEY_MASK  = {2'b00, IDX_KEY_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TMR_MASK  = {2'b00, IDX_TMR_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CLK_MASK  = {2'b00, IDX_CLK_MASK, 2'b00};

    // field widths and lowest bit of each implemented field
    localparam int unsigned EN_W    = 3;  // adc done, pen down, touch update at d7..d5
    localparam int unsigned EN_LSB  = 5;
    localparam int unsigned KEY_W   = 5;  // key13..key10 at d7..d4, key group at d3
    localparam int unsigned KEY_LSB = 3;
    localparam int unsigned TMR_W   = 8;  // full byte
    localparam int unsigned TMR_LSB = 0;
    localparam int unsigned CLK_W   = 6;  // 60 s, 1, 2, 8, 32 hz, lcd at d7..d2
    localparam int unsigned CLK_LSB = 2;

    // reset values
    localparam logic [EN_W-1:0]  EN_RST  = 3'h0;
    localparam logic [KEY_W-1:0] KEY_RST = 5'h00;
    localparam logic [TMR_W-1:0] TMR_RST = 8'h00;
    localparam logic [CLK_W-1:0] CLK_RST = 6'h00;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // bus answer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } ief_bus_state_t;

endpackage : ief_pkg

//--- ief_flag_if.sv
// carrier between the top and one sticky flag bank
// assumes set and clear are one-cycle pulses on the bank's own clock
`timescale 1ns/1ps

interface ief_flag_if #(
    parameter int unsigned W = 8
);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;

    modport bank (input set, input clr, output flags);
    modport ctrl (output set, output clr, input flags);
endinterface : ief_flag_if

//--- ief_flag_bank.sv
// sticky interrupt factor flags, one bit per source
// assumes set pulses come from logic on the same clock
`timescale 1ns/1ps

module ief_flag_bank #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic  i_sys_clk,
    input  wire logic  i_reset,
    // set, clear and flag values
    ief_flag_if.bank   fl
);

    logic [W-1:0] flag_r;
    logic [W-1:0] flag_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // per bit: a new factor wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_comb begin
                flag_nxt[gi] = fl.set[gi] | (flag_r[gi] & ~fl.clr[gi]);  // R12
            end
        end
    endgenerate

    // register the flags, all cleared at reset
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign fl.flags = flag_r;

endmodule : ief_flag_bank

//--- ief_top.sv
// interrupt enable and factor flag bank behind an apb slave
// assumes every source event is a one-cycle pulse from logic on i_sys_clk,
// so no synchroniser is placed on the event inputs
// masks are a local addition, one per
// flag register and in its layout
// one fixed wait state on every access
// o_irq lags a masked-in flag by one cycle
// a write with pstrb[0] low does nothing
//
// Operation
// R1: d7 of enable register enables adc done
// R2: d6 of enable register enables pen down
// R3: d5 of enable register enables touch update
// R4: unused enable and key bits read zero
// R5: key flag d7..d4 latch keys 13..10
// R6: key flag d3 latches key group 00..07
// R7: timer flag d7 latches byte timer underflow
// R8: d6/d4 match, d5/d3 underflow of wide timers
// R9: d2 tx done, d1 rx done flags
// R10: d0 latches serial receive error
// R11: clock flag d7..d4: 60 s, 1, 2, 8 hz
// R12: write one clears flag; set beats clear
// R13: clock flag d3 32 hz, d2 lcd
`timescale 1ns/1ps

module ief_top (
    // clock and reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_reset,
    // apb slave
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [ief_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [ief_pkg::DATA_W-1:0]  i_pwdata,
    input  wire logic [3:0]                  i_pstrb,
    output logic                             o_pready,
    output logic [ief_pkg::DATA_W-1:0]       o_prdata,
    output logic                             o_pslverr,
    // key events: key13, key12, key11, key10, key group
    input  wire logic [ief_pkg::KEY_W-1:0]   i_key_evt,
    // timer and serial events, bit order as the flag register
    input  wire logic [ief_pkg::TMR_W-1:0]   i_tmr_evt,
    // clock timer events: 60 s, 1 hz, 2 hz, 8 hz, 32 hz, lcd
    input  wire logic [ief_pkg::CLK_W-1:0]   i_clk_evt,
    // enables to the adc and touch panel interrupt paths
    output logic                             o_adc_done_irq_en,
    output logic                             o_pen_down_irq_en,
    output logic                             o_touch_update_irq_en,
    // combined interrupt request
    output logic                             o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // flag bank carriers
    // the top drives set and clear
    ief_flag_if #(.W(ief_pkg::KEY_W)) key_if ();
    ief_flag_if #(.W(ief_pkg::TMR_W)) tmr_if ();
    ief_flag_if #(.W(ief_pkg::CLK_W)) clk_if ();

    ////////////////////////////////////////////////////////////////////////////
    // bus state and answer registers
    // answers stand one cycle each
    ief_pkg::ief_bus_state_t            st_r;
    ief_pkg::ief_bus_state_t            st_nxt;
    logic                               pready_r;
    logic                               pready_nxt;
    logic [ief_pkg::DATA_W-1:0]         prdata_r;
    logic [ief_pkg::DATA_W-1:0]         prdata_nxt;
    logic                               pslverr_r;
    logic                               pslverr_nxt;

    // software state
    // masks follow their flag layout
    logic [ief_pkg::EN_W-1:0]           en_r;
    logic [ief_pkg::EN_W-1:0]           en_nxt;
    logic [ief_pkg::KEY_W-1:0]          key_mask_r;
    logic [ief_pkg::KEY_W-1:0]          key_mask_nxt;
    logic [ief_pkg::TMR_W-1:0]          tmr_mask_r;
    logic [ief_pkg::TMR_W-1:0]          tmr_mask_nxt;
    logic [ief_pkg::CLK_W-1:0]          clk_mask_r;
    logic [ief_pkg::CLK_W-1:0]          clk_mask_nxt;
    logic                               irq_r;
    logic                               irq_nxt;

    // per-bank pending terms
    logic                               key_pend;
    logic                               tmr_pend;
    logic                               clk_pend;

    // decode
    // commit: edge where pready is seen
    logic                               hit_en;
    logic                               hit_key;
    logic                               hit_tmr;
    logic                               hit_clk;
    logic                               hit_key_m;
    logic                               hit_tmr_m;
    logic                               hit_clk_m;
    logic                               hit_any;
    logic                               commit;
    logic                               wr_commit;
    logic [ief_pkg::REG_W-1:0]          wbyte;
    logic [ief_pkg::REG_W-1:0]          rbyte;

    ////////////////////////////////////////////////////////////////////////////
    // address decode; only the low byte lane carries register data
    // full compare: no register aliases
    // strobe gates writes, not reads
    always_comb begin
        hit_en    = (i_paddr == ief_pkg::ADDR_ENABLE);
        hit_key   = (i_paddr == ief_pkg::ADDR_KEY_FLAGS);
        hit_tmr   = (i_paddr == ief_pkg::ADDR_TMR_FLAGS);
        hit_clk   = (i_paddr == ief_pkg::ADDR_CLK_FLAGS);
        hit_key_m = (i_paddr == ief_pkg::ADDR_KEY_MASK);
        hit_tmr_m = (i_paddr == ief_pkg::ADDR_TMR_MASK);
        hit_clk_m = (i_paddr == ief_pkg::ADDR_CLK_MASK);
        hit_any   = hit_en | hit_key | hit_tmr | hit_clk | hit_key_m | hit_tmr_m | hit_clk_m;
        // a write lands only on the edge where the master sees pready high
        commit    = i_psel & i_penable & pready_r;
        wr_commit = commit & i_pwrite & i_pstrb[0] & hit_any;
        wbyte     = i_pwdata[ief_pkg::REG_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; bits with no function read zero
    // flags as they stood before the edge;
    // a factor on that edge shows next read
    always_comb begin
        rbyte = '0;
        if (hit_en) begin
            rbyte[ief_pkg::EN_LSB +: ief_pkg::EN_W] = en_r;              // R4
        end else if (hit_key) begin
            rbyte[ief_pkg::KEY_LSB +: ief_pkg::KEY_W] = key_if.flags;    // R4
        end else if (hit_tmr) begin
            rbyte[ief_pkg::TMR_LSB +: ief_pkg::TMR_W] = tmr_if.flags;
        end else if (hit_clk) begin
            rbyte[ief_pkg::CLK_LSB +: ief_pkg::CLK_W] = clk_if.flags;
        end else if (hit_key_m) begin
            rbyte[ief_pkg::KEY_LSB +: ief_pkg::KEY_W] = key_mask_r;
        end else if (hit_tmr_m) begin
            rbyte[ief_pkg::TMR_LSB +: ief_pkg::TMR_W] = tmr_mask_r;
        end else if (hit_clk_m) begin
            rbyte[ief_pkg::CLK_LSB +: ief_pkg::CLK_W] = clk_mask_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer: one wait cycle in the access phase, then pready for one cycle.
    // the wait cycle costs a clock but lets every output come from a flop.
    // unmapped: zero data, pslverr, no write
    always_comb begin
        st_nxt      = st_r;
        pready_nxt  = 1'b0;
        prdata_nxt  = ief_pkg::RDATA_ZERO;
        pslverr_nxt = 1'b0;
        unique case (st_r)
            ief_pkg::ST_IDLE: begin
                // answer stands on the next edge
                if (i_psel & i_penable) begin
                    st_nxt      = ief_pkg::ST_RESP;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = ~hit_any;
                    // reads capture the byte now
                    if (~i_pwrite & hit_any) begin
                        prdata_nxt = {{(ief_pkg::DATA_W - ief_pkg::REG_W){1'b0}}, rbyte};
                    end
                end
            end
            ief_pkg::ST_RESP: begin
                // pready stood one cycle
                st_nxt = ief_pkg::ST_IDLE;
            end
            default: begin
                // broken code: back to idle
                st_nxt = ief_pkg::ST_IDLE;
            end
        endcase
    end

    // register the bus answer
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_r      <= ief_pkg::ST_IDLE;
            pready_r  <= 1'b0;
            prdata_r  <= ief_pkg::RDATA_ZERO;
            pslverr_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable register and interrupt mask registers
    // enables only drive pins
    // masks gate o_irq, never the flags
    always_comb begin
        en_nxt       = en_r;
        key_mask_nxt = key_mask_r;
        tmr_mask_nxt = tmr_mask_r;
        clk_mask_nxt = clk_mask_r;
        if (wr_commit & hit_en) begin
            en_nxt = wbyte[ief_pkg::EN_LSB +: ief_pkg::EN_W];            // R1 R2 R3
        end
        // masks use their flag byte lanes
        if (wr_commit & hit_key_m) begin
            key_mask_nxt = wbyte[ief_pkg::KEY_LSB +: ief_pkg::KEY_W];
        end
        if (wr_commit & hit_tmr_m) begin
            tmr_mask_nxt = wbyte[ief_pkg::TMR_LSB +: ief_pkg::TMR_W];
        end
        if (wr_commit & hit_clk_m) begin
            clk_mask_nxt = wbyte[ief_pkg::CLK_LSB +: ief_pkg::CLK_W];
        end
    end

    // register enables and masks
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            en_r       <= ief_pkg::EN_RST;                               // R1 R2 R3
            key_mask_r <= ief_pkg::KEY_RST;
            tmr_mask_r <= ief_pkg::TMR_RST;
            clk_mask_r <= ief_pkg::CLK_RST;
        end else begin
            en_r       <= en_nxt;
            key_mask_r <= key_mask_nxt;
            tmr_mask_r <= tmr_mask_nxt;
            clk_mask_r <= clk_mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag set and write-one-to-clear strobes
    // a clear lasts the commit cycle only
    // set wins over clear inside each bank
    always_comb begin
        key_if.set = i_key_evt;                                          // R5 R6
        tmr_if.set = i_tmr_evt;                                          // R7 R8 R9 R10
        clk_if.set = i_clk_evt;                                          // R11 R13
        // clears: written ones, own bit lanes
        key_if.clr = (wr_commit & hit_key) ? wbyte[ief_pkg::KEY_LSB +: ief_pkg::KEY_W] : '0;  // R12
        tmr_if.clr = (wr_commit & hit_tmr) ? wbyte[ief_pkg::TMR_LSB +: ief_pkg::TMR_W] : '0;  // R12
        clk_if.clr = (wr_commit & hit_clk) ? wbyte[ief_pkg::CLK_LSB +: ief_pkg::CLK_W] : '0;  // R12
    end

    ////////////////////////////////////////////////////////////////////////////
    // key input flags: key13..key10 and the shared key group flag
    ief_flag_bank #(.W(ief_pkg::KEY_W)) u_key_flags (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .fl        (key_if.bank)
    );

    // programmable timer and serial interface flags
    // d7 byte timer .. d0 rx error
    ief_flag_bank #(.W(ief_pkg::TMR_W)) u_tmr_flags (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .fl        (tmr_if.bank)
    );

    // clock timer and lcd flags
    // d7 60 s .. d2 lcd
    ief_flag_bank #(.W(ief_pkg::CLK_W)) u_clk_flags (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .fl        (clk_if.bank)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt level: any flag whose mask bit is one; lags the flag by a cycle
    always_comb begin
        key_pend = |(key_if.flags & key_mask_r);
        tmr_pend = |(tmr_if.flags & tmr_mask_r);
        clk_pend = |(clk_if.flags & clk_mask_r);
        irq_nxt  = key_pend | tmr_pend | clk_pend;
    end

    // registered: o_irq never glitches
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    // en_r[2:0] holds d7..d5
    assign o_pready              = pready_r;
    assign o_prdata              = prdata_r;
    assign o_pslverr             = pslverr_r;
    assign o_adc_done_irq_en     = en_r[2];      // d7
    assign o_pen_down_irq_en     = en_r[1];      // d6
    assign o_touch_update_irq_en = en_r[0];      // d5
    assign o_irq                 = irq_r;

endmodule : ief_top

//--- ief_checker_assertions.sv
// port-level checks for the interrupt enable and factor flag bank
// assumes binding to ief_top, one clock, synchronous active-high reset
`timescale 1ns/1ps
module ief_checker (
    // clock and reset
    input wire logic                       i_sys_clk,
    input wire logic                       i_reset,
    // apb request and timer events
    input wire logic                       i_psel,
    input wire logic                       i_penable,
    input wire logic                       i_pwrite,
    input wire logic [ief_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [ief_pkg::TMR_W-1:0]  i_tmr_evt,
    // answers and enables
    input wire logic                       o_pready,
    input wire logic [ief_pkg::DATA_W-1:0] o_prdata,
    input wire logic                       o_pslverr,
    input wire logic                       o_adc_done_irq_en,
    input wire logic                       o_pen_down_irq_en,
    input wire logic                       o_touch_update_irq_en
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////
    // first access cycle, and the answer cycle of a read at one address
    sequence access_start;
        i_psel && i_penable && !$past(i_penable);
    endsequence
    sequence read_of(a);
        o_pready && !i_pwrite && i_paddr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ready_one_wait_a:    assert property (access_start |=> o_pready ##1 !o_pready)
        else $error("pready not one wait");
    ready_needs_acc_a:   assert property (o_pready |-> $past(i_psel && i_penable))
        else $error("pready without access");
    rdata_idle_zero_a:   assert property (!o_pready |-> o_prdata == 32'h0000_0000)
        else $error("rdata outside answer");
    rdata_byte_only_a:   assert property (o_pready |-> o_prdata[31:8] == 24'h00_0000)
        else $error("rdata upper bits set");
    error_with_ready_a:  assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    enable_by_write_a:   assert property ($changed({o_adc_done_irq_en, o_pen_down_irq_en,
        o_touch_update_irq_en}) |-> $past(o_pready && i_pwrite && i_paddr == ief_pkg::ADDR_ENABLE))
        else $error("enable changed without write");
    enable_readback_a:   assert property (read_of(ief_pkg::ADDR_ENABLE) |-> o_prdata[7:0] ==
        {o_adc_done_irq_en, o_pen_down_irq_en, o_touch_update_irq_en, 5'h00})
        else $error("enable readback wrong");
    key_unused_zero_a:   assert property (read_of(ief_pkg::ADDR_KEY_FLAGS) |-> o_prdata[2:0] == 3'h0)
        else $error("key unused bits set");
    tmr_flag_latch_a:    assert property (read_of(ief_pkg::ADDR_TMR_FLAGS) |->
        (o_prdata[7:0] & $past(i_tmr_evt, 2)) == $past(i_tmr_evt, 2))
        else $error("timer flag not latched");
endmodule : ief_checker
bind ief_top ief_checker ief_checker_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_tmr_evt(i_tmr_evt),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_adc_done_irq_en(o_adc_done_irq_en), .o_pen_down_irq_en(o_pen_down_irq_en),
    .o_touch_update_irq_en(o_touch_update_irq_en));

//--- ief_apb_cpu.sv
// cpu-side apb master model for the flag bank
// assumes one clock; signals move by nonblocking assignment after a rising edge
`timescale 1ns/1ps
module ief_apb_cpu (
    // clock and answers
    input  wire logic        i_sys_clk,
    input  wire logic        i_pready,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pslverr,
    // request
    output logic             o_psel    = 1'b0,
    output logic             o_penable = 1'b0,
    output logic             o_pwrite  = 1'b0,
    output logic [19:0]      o_paddr   = 20'h00000,
    output logic [31:0]      o_pwdata  = 32'h0000_0000,
    output logic [3:0]       o_pstrb   = 4'h0
);
    ////////////////////////////////////////////////////////////////////////
    // one transfer; waits for pready as long as it takes, the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic e);
        @(posedge i_sys_clk);
        o_psel    <= 1'b1;
        o_pwrite  <= w;
        o_paddr   <= a;
        o_pwdata  <= d;
        o_pstrb   <= s;
        @(posedge i_sys_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (i_pready !== 1'b1);
        rd        = i_prdata;
        e         = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
    endtask : xfer
endmodule : ief_apb_cpu

//--- tb_top.sv
// self-checking bench for the interrupt enable and factor flag bank
// assumes ief_top, the cpu model and the bound checker
`timescale 1ns/1ps
module tb_top;
    logic        i_sys_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic [4:0]  i_key_evt = 5'h00;
    logic [7:0]  i_tmr_evt = 8'h00;
    logic [5:0]  i_clk_evt = 6'h00;
    logic        psel, penable, pwrite, pready, pslverr, irq, en_a, en_p, en_t;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          mismatches  = 0;
    int          checks_done = 0;
    logic [19:0] fl_addr [3] = '{ief_pkg::ADDR_KEY_FLAGS, ief_pkg::ADDR_TMR_FLAGS, ief_pkg::ADDR_CLK_FLAGS};
    logic [19:0] mk_addr [3] = '{ief_pkg::ADDR_KEY_MASK, ief_pkg::ADDR_TMR_MASK, ief_pkg::ADDR_CLK_MASK};
    logic [7:0]  impl    [3] = '{8'hf8, 8'hff, 8'hfc};

    always #5 i_sys_clk = ~i_sys_clk;
    ////////////////////////////////////////////////////////////////////////
    ief_top ief_top_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_key_evt(i_key_evt), .i_tmr_evt(i_tmr_evt),
        .i_clk_evt(i_clk_evt), .o_adc_done_irq_en(en_a), .o_pen_down_irq_en(en_p),
        .o_touch_update_irq_en(en_t), .o_irq(irq));
    ief_apb_cpu cpu (.i_sys_clk(i_sys_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_pstrb(pstrb));
    ////////////////////////////////////////////////////////////////////////
    // shared compare, bus and event helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xf(input logic w, input logic [19:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [7:0] exp, input logic experr, input string nm);
        logic [31:0] rd;
        logic        e;
        cpu.xfer(w, a, {24'h0, d}, s, rd, e);
        chk({nm, " err"}, {31'h0, experr}, {31'h0, e});
        if (!w) chk(nm, {24'h0, exp}, rd);
    endtask : xf
    // drives the events of one flag register from a byte in its bit layout
    task automatic ev(input int r, input logic [7:0] b);
        @(posedge i_sys_clk);
        if (r == 0) i_key_evt <= b[7:3];
        if (r == 1) i_tmr_evt <= b;
        if (r == 2) i_clk_evt <= b[7:2];
        @(posedge i_sys_clk);
        {i_key_evt, i_tmr_evt, i_clk_evt} <= 19'h0;
    endtask : ev
    task automatic irq_at(input int cyc, input logic exp);
        repeat (cyc) @(posedge i_sys_clk);
        #1 chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_at
    ////////////////////////////////////////////////////////////////////////
    // every register clear after reset, unmapped address refused
    task automatic t_reset();
        for (int r = 0; r < 3; r++) begin
            xf(0, fl_addr[r], 0, 4'hf, 8'h00, 0, "flag reset");
            xf(0, mk_addr[r], 0, 4'hf, 8'h00, 0, "mask reset");
        end
        xf(0, ief_pkg::ADDR_ENABLE, 0, 4'hf, 8'h00, 0, "enable reset");
        xf(0, 20'h3fd00, 0, 4'hf, 8'h00, 1, "unmapped read");
        xf(1, 20'h3fd00, 8'hff, 4'hf, 8'h00, 1, "unmapped write");
        $display("test reset done");
    endtask : t_reset
    // enable bits, unused bits, strobe-less write
    task automatic t_enable();
        xf(1, ief_pkg::ADDR_ENABLE, 8'hff, 4'hf, 0, 0, "enable wr");
        xf(0, ief_pkg::ADDR_ENABLE, 0, 4'hf, 8'he0, 0, "enable all");
        chk("enable pins", 32'h7, {29'h0, en_a, en_p, en_t});
        xf(1, ief_pkg::ADDR_ENABLE, 8'h00, 4'h0, 0, 0, "enable nostrb");
        xf(0, ief_pkg::ADDR_ENABLE, 0, 4'hf, 8'he0, 0, "enable kept");
        xf(1, ief_pkg::ADDR_ENABLE, 8'h40, 4'hf, 0, 0, "enable wr");
        xf(0, ief_pkg::ADDR_ENABLE, 0, 4'hf, 8'h40, 0, "enable d6");
        chk("enable pins", 32'h2, {29'h0, en_a, en_p, en_t});
        xf(1, ief_pkg::ADDR_ENABLE, 8'h00, 4'hf, 0, 0, "enable wr");
        $display("test enable done");
    endtask : t_enable
    // latch, write zero, partial write one, full clear on each flag register
    task automatic t_flags();
        for (int r = 0; r < 3; r++) begin
            ev(r, 8'hff);
            xf(0, fl_addr[r], 0, 4'hf, impl[r], 0, "flags set");
            xf(1, fl_addr[r], 8'h00, 4'hf, 0, 0, "flags wr0");
            xf(0, fl_addr[r], 0, 4'hf, impl[r], 0, "flags kept");
            xf(1, fl_addr[r], 8'h55, 4'hf, 0, 0, "flags wr1");
            xf(0, fl_addr[r], 0, 4'hf, impl[r] & 8'haa, 0, "flags part");
            xf(1, fl_addr[r], 8'hff, 4'hf, 0, 0, "flags clr");
            xf(0, fl_addr[r], 0, 4'hf, 8'h00, 0, "flags clear");
        end
        $display("test flags done");
    endtask : t_flags
    // a source still firing while its flag is cleared keeps the flag
    task automatic t_set_wins();
        @(posedge i_sys_clk);
        i_key_evt <= 5'h1f;
        xf(1, ief_pkg::ADDR_KEY_FLAGS, 8'hff, 4'hf, 0, 0, "key clr");
        i_key_evt <= 5'h00;
        xf(0, ief_pkg::ADDR_KEY_FLAGS, 0, 4'hf, 8'hf8, 0, "set wins");
        xf(1, ief_pkg::ADDR_KEY_FLAGS, 8'hff, 4'hf, 0, 0, "key clr");
        i_tmr_evt <= 8'h81;
        xf(0, ief_pkg::ADDR_TMR_FLAGS, 0, 4'hf, 8'h81, 0, "flag mid read");
        i_tmr_evt <= 8'h00;
        xf(1, ief_pkg::ADDR_TMR_FLAGS, 8'hff, 4'hf, 0, 0, "tmr clr");
        xf(0, ief_pkg::ADDR_TMR_FLAGS, 0, 4'hf, 8'h00, 0, "tmr cleared");
        $display("test set wins done");
    endtask : t_set_wins
    // interrupt raised only by a masked-in flag, dropped by clearing it
    task automatic t_irq();
        for (int r = 0; r < 3; r++) begin
            xf(1, mk_addr[r], 8'h80, 4'hf, 0, 0, "mask wr");
            xf(0, mk_addr[r], 0, 4'hf, 8'h80, 0, "mask rd");
            ev(r, 8'h40);
            irq_at(3, 1'b0);
            ev(r, 8'h80);
            irq_at(2, 1'b1);
            xf(1, fl_addr[r], 8'hff, 4'hf, 0, 0, "flags clr");
            irq_at(2, 1'b0);
            xf(1, mk_addr[r], 8'h00, 4'hf, 0, 0, "mask wr");
        end
        $display("test irq done");
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////
    // verdict, reached by the main sequence or the watchdog
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        t_reset();
        t_enable();
        t_flags();
        t_set_wins();
        t_irq();
        wrap_up();
    end
    // the tests take about 270 cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        mismatches++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : tb_top
